// ===== drbc_defs.vh
`ifndef DRBC_DEFS_VH
`define DRBC_DEFS_VH
`define DRBC_SRC_POR        2'h0
`define DRBC_SRC_HOST       2'h2
`define DRBC_SRC_SOFT       2'h3
`define DRBC_SRC_LSB        8
`define DRBC_SRC_MSB        9
`define DRBC_ADDR_KERNEL    20'h14000
`define DRBC_ADDR_MONITOR   20'h14000
`define DRBC_ADDR_USER      20'h10000
`define DRBC_ADDR_CALL      20'h14F00
`define DRBC_ADDR_RETURN    20'h00000
`define DRBC_CMD_NOP        16'h0000
`define DRBC_CMD_EE_READ    16'h0001
`define DRBC_CMD_EE_WRITE   16'h0002
`define DRBC_CMD_PATCH      16'h0003
`define DRBC_CMD_JUMP       16'h0004
`define DRBC_CMD_EE_IMM     16'h0005
`define DRBC_CMD_EE_WREN    16'h0006
`define DRBC_CMD_PWRDN      16'h0007
`define DRBC_REG_CHIP_MODE_STATUS_REG       4'h0
`define DRBC_REG_CORE       4'h1
`define DRBC_REG_MAILBOX    4'h2
`define DRBC_REG_ARG1       4'h3
`define DRBC_REG_ARG2       4'h4
`define DRBC_REG_ARG3       4'h5
`define DRBC_REG_PLL        4'h6
`define DRBC_REG_STATUS     4'h7
`define DRBC_REG_KDONE      4'h8
`define DRBC_REG_CLEARED    4'h9
`define DRBC_STACK_STATUS_RST      8'h55
`define DRBC_CONDITION_CODE_RST      4'h8
`define DRBC_CORE_SOFT_BIT  0
`define DRBC_CORE_CALL_BIT  1
`define DRBC_POR_CYCLES     8
`endif

// ===== drbc_core_state.v
`timescale 1ns/1ps
`default_nettype none
`include "drbc_defs.vh"
// per-core architectural state loaded with its reset values (stack_status 8'h55, condition_code 4'h8, rest zero) by any reset or reboot
module drbc_core_state (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        reboot,
    input  wire        timer_event,
    input  wire        booting,
    output reg  [15:0] arith_status,
    output reg  [15:0] mode_status,
    output reg  [7:0]  stack_status,
    output reg  [3:0]  condition_code,
    output reg  [15:0] interrupt_mask,
    output reg  [15:0] interrupt_latch,
    output reg  [15:0] interrupt_control,
    output reg  [7:0]  page_regs,
    output reg         timer_overrun
);
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            arith_status      <= 16'h0000;
            mode_status       <= 16'h0000;
            stack_status      <= `DRBC_STACK_STATUS_RST;
            condition_code    <= `DRBC_CONDITION_CODE_RST;
            interrupt_mask    <= 16'h0000;
            interrupt_latch   <= 16'h0000;
            interrupt_control <= 16'h0000;
            page_regs         <= 8'h00;
            timer_overrun     <= 1'b0;
        end else if (reboot) begin
            arith_status      <= 16'h0000;
            mode_status       <= 16'h0000;
            stack_status      <= `DRBC_STACK_STATUS_RST;
            condition_code    <= `DRBC_CONDITION_CODE_RST;
            interrupt_mask    <= 16'h0000;
            interrupt_latch   <= 16'h0000;
            interrupt_control <= 16'h0000;
            page_regs         <= 8'h00;
            timer_overrun     <= 1'b0;
        end else if (timer_event && booting) begin
            // masked during boot; a second event is an overrun
            if (interrupt_latch[0])
                timer_overrun <= 1'b1;
            interrupt_latch[0] <= 1'b1;
        end
    end
endmodule // drbc_core_state
`default_nettype wire

// ===== drbc_reset_boot.v
`timescale 1ns/1ps
`default_nettype none
`include "drbc_defs.vh"
module drbc_reset_boot #(
    parameter POR_CYCLES = `DRBC_POR_CYCLES
) (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        power_on_reset_n,
    input  wire        host_reset,
    input  wire        timer_event,
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    output reg         core_reset,
    output reg  [19:0] fetch_addr,
    output reg         fetch_load,
    output reg         int_mask_all,
    output reg         autobuf_disable,
    output reg  [15:0] kernel_cmd,
    output reg         kernel_cmd_valid,
    output reg  [1:0]  clock_multiplier_mode
);
    localparam ST_RESET = 3'h0;
    localparam ST_BOOT  = 3'h1;
    localparam ST_POLL  = 3'h2;
    localparam ST_EXEC  = 3'h3;
    localparam ST_RUN   = 3'h4;

    // pin and host reset come from outside the clock domain
    reg        por_meta_reg, por_sync_reg;
    reg        host_meta_reg, host_sync_reg;
    reg        tmr_meta_reg, tmr_sync_reg;
    reg [7:0]  por_cnt_reg;
    reg [1:0]  reset_source_code;
    reg [2:0]  state_reg;
    reg [15:0] mailbox_reg, arg1_reg, arg2_reg, arg3_reg;
    reg        soft_reset_request;
    reg        call_active_reg;
    reg        ee_wren_reg;
    reg        powered_down_reg;
    wire       reboot;
    wire [15:0] arith_status, mode_status, interrupt_mask, interrupt_latch, interrupt_control;
    wire [7:0] stack_status, page_regs;
    wire [3:0] condition_code;
    wire       timer_overrun;
    wire       in_reset;
    wire [15:0] chip_mode_status_reg;

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            por_meta_reg  <= 1'b0;
            por_sync_reg  <= 1'b0;
            host_meta_reg <= 1'b0;
            host_sync_reg <= 1'b0;
            tmr_meta_reg  <= 1'b0;
            tmr_sync_reg  <= 1'b0;
        end else begin
            por_meta_reg  <= power_on_reset_n;
            por_sync_reg  <= por_meta_reg;
            host_meta_reg <= host_reset;
            host_sync_reg <= host_meta_reg;
            tmr_meta_reg  <= timer_event;
            tmr_sync_reg  <= tmr_meta_reg;
        end
    end

    // internal power-on stretch restarts while the pin is low
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            por_cnt_reg <= 8'h00;
        else if (!por_sync_reg)
            por_cnt_reg <= 8'h00;
        else if (por_cnt_reg != POR_CYCLES[7:0])
            por_cnt_reg <= por_cnt_reg + 8'h01;
    end

    assign in_reset = (por_cnt_reg != POR_CYCLES[7:0]) || host_sync_reg || soft_reset_request;
    assign reboot   = in_reset;
    assign chip_mode_status_reg = {6'h00, reset_source_code, 6'h00, clock_multiplier_mode};

    // source latched while reset is held, so kernel sees it at release
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            reset_source_code <= `DRBC_SRC_POR;
        else if (por_cnt_reg != POR_CYCLES[7:0])
            reset_source_code <= `DRBC_SRC_POR;
        else if (host_sync_reg)
            reset_source_code <= `DRBC_SRC_HOST;
        else if (soft_reset_request)
            reset_source_code <= `DRBC_SRC_SOFT;
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg          <= ST_RESET;
            soft_reset_request <= 1'b0;
            mailbox_reg        <= 16'h0000;
            arg1_reg           <= 16'h0000;
            arg2_reg           <= 16'h0000;
            arg3_reg           <= 16'h0000;
            call_active_reg    <= 1'b0;
            ee_wren_reg        <= 1'b0;
            powered_down_reg   <= 1'b0;
            clock_multiplier_mode <= 2'h0;
            core_reset         <= 1'b1;
            fetch_addr         <= `DRBC_ADDR_KERNEL;
            fetch_load         <= 1'b0;
            int_mask_all       <= 1'b1;
            autobuf_disable    <= 1'b1;
            kernel_cmd         <= `DRBC_CMD_NOP;
            kernel_cmd_valid   <= 1'b0;
            reg_rdata          <= 16'h0000;
        end else begin
            fetch_load       <= 1'b0;
            kernel_cmd_valid <= 1'b0;
            reg_rdata        <= 16'h0000;
            if (soft_reset_request)
                soft_reset_request <= 1'b0; // one-cycle request, self clearing
            if (reg_wr) begin
                case (reg_addr)
                    `DRBC_REG_CORE: begin
                        soft_reset_request <= reg_wdata[`DRBC_CORE_SOFT_BIT];
                        if (reg_wdata[`DRBC_CORE_CALL_BIT] && state_reg == ST_RUN)
                            call_active_reg <= 1'b1;
                    end
                    `DRBC_REG_MAILBOX: mailbox_reg <= reg_wdata;
                    `DRBC_REG_ARG1:    arg1_reg <= reg_wdata;
                    `DRBC_REG_ARG2:    arg2_reg <= reg_wdata;
                    `DRBC_REG_ARG3:    arg3_reg <= reg_wdata;
                    `DRBC_REG_PLL:     clock_multiplier_mode <= reg_wdata[1:0];
                    default: ;
                endcase
            end
            if (reg_rd) begin
                case (reg_addr)
                    `DRBC_REG_CHIP_MODE_STATUS_REG:    reg_rdata <= chip_mode_status_reg;
                    `DRBC_REG_CORE:    reg_rdata <= {13'h0000, powered_down_reg, call_active_reg, 1'b0};
                    `DRBC_REG_MAILBOX: reg_rdata <= mailbox_reg;
                    `DRBC_REG_ARG1:    reg_rdata <= arg1_reg;
                    `DRBC_REG_ARG2:    reg_rdata <= arg2_reg;
                    `DRBC_REG_ARG3:    reg_rdata <= arg3_reg;
                    `DRBC_REG_PLL:     reg_rdata <= {14'h0000, clock_multiplier_mode};
                    `DRBC_REG_STATUS:  reg_rdata <= {timer_overrun, ee_wren_reg, state_reg, 3'h0, stack_status};
                    `DRBC_REG_KDONE:   reg_rdata <= {12'h000, condition_code};
                    // or of the core state cleared to zero, except timer_overrun; zero after any reboot
                    `DRBC_REG_CLEARED: reg_rdata <= arith_status | mode_status | interrupt_mask | interrupt_latch
                                                    | interrupt_control | {8'h00, page_regs};
                    default:           reg_rdata <= 16'h0000;
                endcase
            end
            // mailbox and argument words survive a reboot
            if (in_reset) begin
                state_reg       <= ST_RESET;
                core_reset      <= 1'b1;
                int_mask_all    <= 1'b1;
                autobuf_disable <= 1'b1;
                call_active_reg <= 1'b0;
                powered_down_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_RESET: begin
                        core_reset <= 1'b0;
                        fetch_load <= 1'b1;
                        // kernel entry depends on recorded source
                        if (reset_source_code == `DRBC_SRC_POR) begin
                            fetch_addr <= `DRBC_ADDR_KERNEL;
                            state_reg  <= ST_BOOT;
                        end else if (reset_source_code == `DRBC_SRC_HOST) begin
                            fetch_addr <= `DRBC_ADDR_MONITOR;
                            state_reg  <= ST_POLL;
                        end else begin
                            fetch_addr <= `DRBC_ADDR_USER;
                            state_reg  <= ST_RUN;
                            int_mask_all    <= 1'b0;
                            autobuf_disable <= 1'b0;
                        end
                    end
                    ST_BOOT: state_reg <= ST_POLL;
                    ST_POLL, ST_RUN: begin
                        // command word written last, so arguments are settled
                        if ((state_reg == ST_POLL || call_active_reg) && !(reg_wr && reg_addr == `DRBC_REG_MAILBOX)
                            && mailbox_reg != `DRBC_CMD_NOP) begin
                            kernel_cmd       <= mailbox_reg;
                            kernel_cmd_valid <= 1'b1;
                            state_reg        <= ST_EXEC;
                        end else if (state_reg == ST_RUN && call_active_reg) begin
                            call_active_reg <= 1'b0;
                        end
                    end
                    ST_EXEC: begin
                        mailbox_reg <= `DRBC_CMD_NOP;
                        state_reg   <= call_active_reg ? ST_RUN : ST_POLL;
                        call_active_reg <= 1'b0;
                        case (kernel_cmd)
                            `DRBC_CMD_JUMP: begin
                                fetch_addr      <= {4'h0, arg2_reg};
                                fetch_load      <= 1'b1;
                                state_reg       <= ST_RUN;
                                int_mask_all    <= 1'b0;
                                autobuf_disable <= 1'b0;
                            end
                            `DRBC_CMD_EE_WREN: ee_wren_reg <= 1'b1;
                            `DRBC_CMD_EE_WRITE, `DRBC_CMD_EE_IMM: ee_wren_reg <= ee_wren_reg;
                            `DRBC_CMD_PWRDN: powered_down_reg <= 1'b1;
                            default: ;
                        endcase
                    end
                    default: state_reg <= ST_RESET;
                endcase
            end
        end
    end

    drbc_core_state u_core_state (
        .clock             (clock),
        .sys_rst           (sys_rst),
        .reboot            (reboot),
        .timer_event       (tmr_sync_reg),
        .booting           (int_mask_all),
        .arith_status      (arith_status),
        .mode_status       (mode_status),
        .stack_status      (stack_status),
        .condition_code    (condition_code),
        .interrupt_mask    (interrupt_mask),
        .interrupt_latch   (interrupt_latch),
        .interrupt_control (interrupt_control),
        .page_regs         (page_regs),
        .timer_overrun     (timer_overrun)
    );
endmodule // drbc_reset_boot
`default_nettype wire

// ===== drbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side: forces a hard reset, held for HOLD cycles (slow host uses a large HOLD)
module drbc_host_model #(
    parameter int HOLD = 4
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic force_req,
    output var  logic host_reset
);
    int cnt;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 0;
            host_reset <= 1'b0;
        end else if (force_req) begin
            cnt <= HOLD;
            host_reset <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else begin
            cnt <= 0;
            host_reset <= 1'b0;
        end
    end
endmodule // drbc_host_model
`default_nettype wire

// ===== drbc_reset_boot_chk.sv
`timescale 1ns/1ps
`default_nettype none
module drbc_chk #(
    parameter POR_CYCLES = 8
) (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        power_on_reset_n,
    input wire logic        host_reset,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        core_reset,
    input wire logic        int_mask_all,
    input wire logic        autobuf_disable,
    input wire logic [15:0] kernel_cmd,
    input wire logic        kernel_cmd_valid,
    input wire logic [1:0]  clock_multiplier_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_src_legal; reg_rd && reg_addr == 4'h0 |=> reg_rdata[9:8] != 2'b01; endproperty
    a_src_legal: assert property (p_src_legal) else $error("reserved source code read");
    property p_por_pin; !power_on_reset_n |-> ##[1:5] core_reset; endproperty
    a_por_pin: assert property (p_por_pin) else $error("pin reset not taken");
    property p_host; $rose(host_reset) |-> ##[1:6] core_reset; endproperty
    a_host: assert property (p_host) else $error("host reset not taken");
    property p_soft; reg_wr && reg_addr == 4'h1 && reg_wdata[0] |-> ##[1:4] core_reset; endproperty
    a_soft: assert property (p_soft) else $error("soft reset not taken");
    property p_cmd_range; kernel_cmd_valid |-> kernel_cmd inside {[16'h0001:16'h0007]}; endproperty
    a_cmd_range: assert property (p_cmd_range) else $error("command out of range");
    property p_cmd_pulse; kernel_cmd_valid |=> !kernel_cmd_valid; endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command strobe too long");
    property p_mask; core_reset |-> int_mask_all && autobuf_disable; endproperty
    a_mask: assert property (p_mask) else $error("interrupts open during reset");
    property p_pll_wr; reg_wr && reg_addr == 4'h6 |=> clock_multiplier_mode == $past(reg_wdata[1:0]); endproperty
    a_pll_wr: assert property (p_pll_wr) else $error("multiplier mode not updated");
    property p_pll_rd; reg_rd && reg_addr == 4'h0 |=> reg_rdata[1:0] == $past(clock_multiplier_mode); endproperty
    a_pll_rd: assert property (p_pll_rd) else $error("multiplier mode misread");
    c_jump: cover property (kernel_cmd_valid && kernel_cmd == 16'h0004);
    c_boot: cover property ($fell(core_reset));
    c_host: cover property ($rose(host_reset));
endmodule // drbc_chk
bind drbc_reset_boot drbc_chk #(.POR_CYCLES(POR_CYCLES)) drbc_chk_inst (.*);
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 0, sys_rst = 1, power_on_reset_n = 1, force_req = 0, reg_wr = 0, reg_rd = 0, timer_event = 0;
    logic host_reset, core_reset, fetch_load, int_mask_all, autobuf_disable, kernel_cmd_valid;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, kernel_cmd, rd_val, last_cmd;
    logic [19:0] fetch_addr, last_fetch;
    logic [1:0] clock_multiplier_mode;
    int n_mismatch = 0, n_checks = 0, n_cmd = 0;
    logic [15:0] cmds [7] = '{16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0006, 16'h0007, 16'h0004};
    drbc_host_model #(.HOLD(6)) drbc_host_model_inst (.clock(clock), .sys_rst(sys_rst),
        .force_req(force_req), .host_reset(host_reset));
    drbc_reset_boot #(.POR_CYCLES(4)) drbc_reset_boot_inst (.clock(clock), .sys_rst(sys_rst),
        .power_on_reset_n(power_on_reset_n), .host_reset(host_reset), .timer_event(timer_event),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .core_reset(core_reset), .fetch_addr(fetch_addr),
        .fetch_load(fetch_load), .int_mask_all(int_mask_all), .autobuf_disable(autobuf_disable),
        .kernel_cmd(kernel_cmd), .kernel_cmd_valid(kernel_cmd_valid),
        .clock_multiplier_mode(clock_multiplier_mode));
    initial forever #4 clock = ~clock;
    always @(posedge clock) begin
        if (fetch_load) last_fetch <= fetch_addr;
        if (kernel_cmd_valid) begin
            last_cmd <= kernel_cmd;
            n_cmd <= n_cmd + 1;
        end
    end
    task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            n_mismatch++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        rd_val = reg_rdata;
    endtask
    // bounded: a design that never leaves reset is caught by the counts, not a hang
    task automatic wait_boot();
        for (int i = 0; i < 40 && !core_reset; i++) @(posedge clock);
        for (int i = 0; i < 100 && core_reset; i++) @(posedge clock);
        repeat (6) @(posedge clock);
        chk("core_reset", {19'h0, core_reset}, 20'h0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        wait_boot();
        rd(4'h0);
        chk("power-on source", {18'h0, rd_val[9:8]}, 20'h0);
        chk("power-on entry", last_fetch, 20'h14000);
        rd(4'h7);
        chk("stack_status", {12'h0, rd_val[7:0]}, 20'h55);
        rd(4'h8);
        chk("condition_code", {4'h0, rd_val}, 20'h8);
        rd(4'h9);
        chk("cleared state", {4'h0, rd_val}, 20'h0);
        rd(4'hF);
        chk("unmapped read", {4'h0, rd_val}, 20'h0);
        wr(4'h6, 16'h0002);
        rd(4'h0);
        chk("mode in status", {18'h0, rd_val[1:0]}, 20'h2);
        chk("mode port", {18'h0, clock_multiplier_mode}, 20'h2);
        $display("power-on test done");
        @(posedge clock) force_req <= 1'b1;
        @(posedge clock) force_req <= 1'b0;
        wait_boot();
        rd(4'h0);
        chk("host source", {18'h0, rd_val[9:8]}, 20'h2);
        chk("monitor entry", last_fetch, 20'h14000);
        $display("host reset test done");
        // first pulse during boot is latched, the second one overruns
        for (int k = 0; k < 2; k++) begin
            @(posedge clock) timer_event <= 1'b1;
            @(posedge clock) timer_event <= 1'b0;
            repeat (4) @(posedge clock);
            rd(4'h7);
            chk("timer overrun", {19'h0, rd_val[15]}, {19'h0, k[0]});
            rd(4'h9);
            chk("timer latch", {4'h0, rd_val}, 20'h1);
        end
        $display("timer test done");
        foreach (cmds[i]) begin
            wr(4'h3, 16'h0010);
            wr(4'h4, 16'h1234);
            wr(4'h5, 16'h0001);
            wr(4'h2, cmds[i]);
            repeat (12) @(posedge clock);
            chk("command", {4'h0, last_cmd}, {4'h0, cmds[i]});
            rd(4'h2);
            chk("mailbox cleared", {4'h0, rd_val}, 20'h0);
        end
        chk("command count", n_cmd, 20'h7);
        chk("jump target", last_fetch, 20'h01234);
        rd(4'h7);
        chk("eeprom write enabled", {19'h0, rd_val[14]}, 20'h1);
        rd(4'h1);
        chk("powered down", {19'h0, rd_val[2]}, 20'h1);
        wr(4'h2, 16'h0006);
        wr(4'h1, 16'h0002);
        repeat (12) @(posedge clock);
        chk("called command", {4'h0, last_cmd}, 20'h6);
        chk("call count", n_cmd, 20'h8);
        rd(4'h1);
        chk("call returned", {19'h0, rd_val[1]}, 20'h0);
        $display("command test done");
        wr(4'h1, 16'h0001);
        wait_boot();
        rd(4'h0);
        chk("soft source", {18'h0, rd_val[9:8]}, 20'h3);
        chk("user entry", last_fetch, 20'h10000);
        chk("masks open", {19'h0, int_mask_all}, 20'h0);
        rd(4'h4);
        chk("argument kept", {4'h0, rd_val}, 20'h01234);
        rd(4'h9);
        chk("latch cleared", {4'h0, rd_val}, 20'h0);
        rd(4'h7);
        chk("overrun cleared", {19'h0, rd_val[15]}, 20'h0);
        $display("soft reset test done");
        @(posedge clock) power_on_reset_n <= 1'b0;
        repeat (5) @(posedge clock);
        power_on_reset_n <= 1'b1;
        wait_boot();
        rd(4'h0);
        chk("pin source", {18'h0, rd_val[9:8]}, 20'h0);
        chk("pin entry", last_fetch, 20'h14000);
        chk("masks held", {19'h0, int_mask_all}, 20'h1);
        $display("power-on pin test done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
